//--- include/pdl_if.sv
// link between microcontroller end and pre-driver logic end
`timescale 1ns/100ps
`default_nettype none
interface pdl_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe_n;
  logic so_line;
  logic [2:0] host_high_n;
  logic [2:0] host_low;
  logic cmd_oe_n;
  logic phase_a_high_cmd_n;
  logic phase_b_high_cmd_n;
  logic phase_c_high_cmd_n;
  logic phase_a_low_cmd;
  logic phase_b_low_cmd;
  logic phase_c_low_cmd;
  logic drive_enable_a;
  logic drive_enable_b;
  logic fault_irq;
  logic overcurrent_flag_out;
  // undriven command pins: pull-up on high side, pull-down on low side
  assign phase_a_high_cmd_n = cmd_oe_n ? 1'h1 : host_high_n[0];
  assign phase_b_high_cmd_n = cmd_oe_n ? 1'h1 : host_high_n[1];
  assign phase_c_high_cmd_n = cmd_oe_n ? 1'h1 : host_high_n[2];
  assign phase_a_low_cmd = cmd_oe_n ? 1'h0 : host_low[0];
  assign phase_b_low_cmd = cmd_oe_n ? 1'h0 : host_low[1];
  assign phase_c_low_cmd = cmd_oe_n ? 1'h0 : host_low[2];
  // released serial output reads low
  assign so_line = so_oe_n ? 1'h0 : so;
  modport dev (
    input cs_n, sclk, si, drive_enable_a, drive_enable_b,
    input phase_a_high_cmd_n, phase_b_high_cmd_n, phase_c_high_cmd_n,
    input phase_a_low_cmd, phase_b_low_cmd, phase_c_low_cmd,
    output so, so_oe_n, fault_irq, overcurrent_flag_out
  );
  modport host (
    output cs_n, sclk, si, host_high_n, host_low, cmd_oe_n,
    output drive_enable_a, drive_enable_b,
    input so_line, fault_irq, overcurrent_flag_out
  );
endinterface
`default_nettype wire

//--- include/pdl_pkg.sv
// shared constants of the pre-driver logic link: timing, commands, resets
package pdl_pkg;
  // system clock and serial clock rates
  localparam int CLK_MHZ = 250;
  localparam int SCLK_NOM_KHZ = 3000;
  localparam int SCLK_MAX_KHZ = 5000;
  // half period of the generated serial clock, rounded up so rate stays low
  localparam int HALF_CYC = (CLK_MHZ * 1000 + 2 * SCLK_NOM_KHZ - 1) /
                            (2 * SCLK_NOM_KHZ);
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC);
  // deadtime between complementary drivers, least time rounded up
  localparam int DEAD_NS = 500;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] DEAD_CNT = 8'(DEAD_CYC);
  // serial command byte: opcode in the upper nibble, data in the lower
  localparam int CMD_W = 8;
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam logic [3:0] OP_STATUS = 4'h0;
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_MASK_FIRST = 4'h2;
  localparam logic [3:0] OP_MASK_SECOND = 4'h3;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // pin synchroniser reset: select and high-side commands idle high
  localparam logic [10:0] SYNC_RST = 11'h438;
  // host register map on classic wishbone, byte addresses
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PHASE = 4'h8;
  localparam logic [8:0] PHASE_RST = 9'h000;
  localparam int PH_EN_A = 6;
  localparam int PH_EN_B = 7;
  localparam int PH_DRIVE = 8;
  // command queue in the host
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
endpackage

//--- rtl/pdl_device.sv
// pre-driver logic end: serial slave, fault interrupt, phase drive logic
// Overview of operation
// - sample input on falling clock, MSB first
// - serial output released while select is high
// - output changes on rising edge, master captures falling
// - traffic accepted only while select is low
// - master keeps serial clock near 3, under 5 MHz
// - unmasked fault latches interrupt until clear command
// - two mask registers suppress individual fault sources
// - high-side command active low, idles off
// - low-side command active high, idles off
// - over-current flag high while current exceeds threshold
// - both enables needed, else all gates off
// - high side waits for one low-side pulse
// - leading edge drops complementary, selected after deadtime
// - deadtime starts at turn-off; later commands immediate
`timescale 1ns/100ps
`default_nettype none
module pdl_device (
  input wire logic clk_i,
  input wire logic rst_i,
  pdl_if.dev link,
  input wire logic [7:0] fault_i,
  input wire logic [7:0] sense_code_i,
  input wire logic [7:0] overcurrent_threshold_in_i,
  output logic [2:0] high_gate_o,
  output logic [2:0] low_gate_o
);
  logic [10:0] s1_q, s2_q;
  logic cs_s, sclk_s, si_s, ena_s, enb_s;
  logic [2:0] hs_n_s, ls_s;
  logic sclk_prev_q, cs_prev_q;
  logic [7:0] rx_q, rx_d, tx_q, tx_d, latch_q, latch_d;
  logic [2:0] bit_q, bit_d;
  logic so_q, so_d, so_oe_n_q, so_oe_n_d;
  logic [3:0] fault_mask_second_q, fault_mask_second_d, mask2_q, mask2_d;
  logic irq_q, irq_d, oc_q, oc_d;
  logic [2:0] hs_prev_q, ls_prev_q;
  logic [2:0] want_hi_q, want_hi_d, want_lo_q, want_lo_d;
  logic [2:0] boot_q, boot_d, hg_q, hg_d, lg_q, lg_d;
  logic [7:0] dt_q [3];
  logic [7:0] dt_d [3];
  // every pin from the far end passes two flops; only s2 is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= pdl_pkg::SYNC_RST;
      s2_q <= pdl_pkg::SYNC_RST;
    end else begin
      s1_q <= {link.cs_n, link.sclk, link.si,
               link.drive_enable_a, link.drive_enable_b,
               link.phase_c_high_cmd_n, link.phase_b_high_cmd_n,
               link.phase_a_high_cmd_n, link.phase_c_low_cmd,
               link.phase_b_low_cmd, link.phase_a_low_cmd};
      s2_q <= s1_q;
    end
  end
  assign cs_s = s2_q[10];
  assign sclk_s = s2_q[9];
  assign si_s = s2_q[8];
  assign ena_s = s2_q[7];
  assign enb_s = s2_q[6];
  assign hs_n_s = s2_q[5:3];
  assign ls_s = s2_q[2:0];

  // serial slave, command decode, fault latch and interrupt
  always_comb begin
    logic [7:0] cmd;
    logic [7:0] live;
    logic clear;
    cmd = {rx_q[6:0], si_s};
    live = 8'h00;
    clear = 1'h0;
    rx_d = rx_q;
    tx_d = tx_q;
    bit_d = bit_q;
    so_d = so_q;
    fault_mask_second_d = fault_mask_second_q;
    mask2_d = mask2_q;
    so_oe_n_d = cs_s;
    if (cs_s) begin
      // partial byte is dropped when select rises early
      bit_d = 3'h0;
    end else begin
      if (cs_prev_q) begin
        // status snapshot taken as the frame opens
        tx_d = latch_q;
      end else if (sclk_s & ~sclk_prev_q) begin
        so_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'h0};
      end
      if (~sclk_s & sclk_prev_q) begin
        rx_d = cmd;
        bit_d = bit_q + 3'h1;
        if (bit_q == pdl_pkg::LAST_BIT) begin
          case (cmd[pdl_pkg::OP_MSB:pdl_pkg::OP_LSB])
            pdl_pkg::OP_CLEAR: clear = 1'h1;
            pdl_pkg::OP_MASK_FIRST: fault_mask_second_d = cmd[3:0];
            pdl_pkg::OP_MASK_SECOND: mask2_d = cmd[3:0];
            default: clear = 1'h0;
          endcase
        end
      end
    end
    // a set bit suppresses its source
    live = fault_i & ~{mask2_q, fault_mask_second_q};
    // new fault in the clearing cycle wins over the clear
    latch_d = (clear ? 8'h00 : latch_q) | live;
    irq_d = (clear ? 1'h0 : irq_q) | (|live);
    oc_d = sense_code_i > overcurrent_threshold_in_i;
  end

  // phase drive: edge-selected side, deadtime, bootstrap interlock
  always_comb begin
    logic en;
    logic hr;
    logic lr;
    en = ena_s & enb_s;
    hr = 1'h0;
    lr = 1'h0;
    want_hi_d = want_hi_q;
    want_lo_d = want_lo_q;
    boot_d = boot_q;
    hg_d = hg_q;
    lg_d = lg_q;
    dt_d = dt_q;
    for (int p = 0; p < 3; p++) begin
      hr = ~hs_n_s[p];
      lr = ls_s[p];
      // simultaneous leading edges pick the low side, the safe one
      if (lr & ~ls_prev_q[p]) begin
        want_lo_d[p] = 1'h1;
        want_hi_d[p] = 1'h0;
      end else if (hr & ~hs_prev_q[p]) begin
        want_hi_d[p] = 1'h1;
        want_lo_d[p] = 1'h0;
      end
      if (~hr) want_hi_d[p] = 1'h0;
      if (~lr) want_lo_d[p] = 1'h0;
      if (dt_q[p] != 8'h00) begin
        dt_d[p] = dt_q[p] - 8'h01;
      end
      hg_d[p] = en & want_hi_d[p] & boot_q[p] & ~lg_q[p] &
                (dt_q[p] == 8'h00);
      lg_d[p] = en & want_lo_d[p] & ~hg_q[p] & (dt_q[p] == 8'h00);
      if ((hg_q[p] & ~hg_d[p]) | (lg_q[p] & ~lg_d[p])) begin
        dt_d[p] = pdl_pkg::DEAD_CNT;
      end
      // bootstrap charge is forgotten whenever drive is disabled
      boot_d[p] = en & (boot_q[p] | lg_q[p]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'h0;
      cs_prev_q <= 1'h1;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      latch_q <= 8'h00;
      bit_q <= 3'h0;
      so_q <= 1'h0;
      so_oe_n_q <= 1'h1;
      fault_mask_second_q <= pdl_pkg::MASK_RST;
      mask2_q <= pdl_pkg::MASK_RST;
      irq_q <= 1'h0;
      oc_q <= 1'h0;
      hs_prev_q <= 3'h0;
      ls_prev_q <= 3'h0;
      want_hi_q <= 3'h0;
      want_lo_q <= 3'h0;
      boot_q <= 3'h0;
      hg_q <= 3'h0;
      lg_q <= 3'h0;
      dt_q <= '{default: 8'h00};
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
      rx_q <= rx_d;
      tx_q <= tx_d;
      latch_q <= latch_d;
      bit_q <= bit_d;
      so_q <= so_d;
      so_oe_n_q <= so_oe_n_d;
      fault_mask_second_q <= fault_mask_second_d;
      mask2_q <= mask2_d;
      irq_q <= irq_d;
      oc_q <= oc_d;
      hs_prev_q <= ~hs_n_s;
      ls_prev_q <= ls_s;
      want_hi_q <= want_hi_d;
      want_lo_q <= want_lo_d;
      boot_q <= boot_d;
      hg_q <= hg_d;
      lg_q <= lg_d;
      dt_q <= dt_d;
    end
  end
  assign link.so = so_q;
  assign link.so_oe_n = so_oe_n_q;
  assign link.fault_irq = irq_q;
  assign link.overcurrent_flag_out = oc_q;
  assign high_gate_o = hg_q;
  assign low_gate_o = lg_q;
endmodule
`default_nettype wire

//--- rtl/pdl_host.sv
// microcontroller end: wishbone registers, command queue, serial master
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pdl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [AW:0] count_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
  assign count_o = cnt_q;
  // pointers wrap at a power-of-two depth
  always_comb begin
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data_i;
      wp_d = wp_q + 1'h1;
    end
    if (pop) begin
      rp_d = rp_q + 1'h1;
    end
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'h1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    mem_q <= mem_d;
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

module pdl_host (
  input wire logic clk_i,
  input wire logic rst_i,
  pdl_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LEAD = 6'h02,
    ST_HIGH = 6'h04,
    ST_LOW = 6'h08,
    ST_LAG = 6'h10,
    ST_GAP = 6'h20
  } pdl_state_t;
  pdl_state_t st_q, st_d;
  logic [2:0] s1_q, s2_q;
  logic [7:0] cnt_q, cnt_d, sh_q, sh_d, rx_q, rx_d, last_q, last_d;
  logic [2:0] bit_q, bit_d;
  logic cs_n_q, cs_n_d, sclk_q, sclk_d, si_q, si_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [8:0] phase_q, phase_d;
  logic [2:0] boot_q, boot_d, hh_n_q, hh_n_d, hl_q, hl_d;
  logic oe_n_q, oe_n_d, ena_q, ena_d, enb_q, enb_d;
  logic q_valid, q_ready, q_pop, req, wr, is_cmd;
  logic [7:0] q_data;
  logic [5:0] q_count;
  // pins from the device side cross into this clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {link.so_line, link.fault_irq, link.overcurrent_flag_out};
      s2_q <= s1_q;
    end
  end
  // a full queue holds off the bus ack, stalling software
  pdl_fifo #(
    .WIDTH(pdl_pkg::CMD_W),
    .DEPTH(pdl_pkg::FIFO_DEPTH),
    .AW(pdl_pkg::FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr & is_cmd & wb_sel_i[0]),
    .in_ready_o(q_ready),
    .in_data_i(wb_dat_i[7:0]),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop),
    .out_data_o(q_data),
    .count_o(q_count)
  );
  // bus slave: ack one cycle after the request, writes land on ack
  always_comb begin
    is_cmd = wb_adr_i == pdl_pkg::ADDR_CMD;
    req = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    ack_d = req & (~(wb_we_i & is_cmd) | q_ready);
    dat_d = dat_q;
    phase_d = phase_q;
    if (ack_d & ~wb_we_i) begin
      if (is_cmd) begin
        dat_d = {24'h000000, last_q};
      end else if (wb_adr_i == pdl_pkg::ADDR_STATUS) begin
        dat_d = {23'h000000, q_count, ~st_q[0] | q_valid, s2_q[1:0]};
      end else if (wb_adr_i == pdl_pkg::ADDR_PHASE) begin
        dat_d = {23'h000000, phase_q};
      end else begin
        dat_d = 32'h00000000;
      end
    end
    if (wr & wb_adr_i == pdl_pkg::ADDR_PHASE) begin
      if (wb_sel_i[0]) phase_d[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) phase_d[8] = wb_dat_i[8];
    end
    ena_d = phase_q[pdl_pkg::PH_EN_A];
    enb_d = phase_q[pdl_pkg::PH_EN_B];
    oe_n_d = ~phase_q[pdl_pkg::PH_DRIVE];
    // high side held back until the low side has been pulsed
    boot_d = (ena_d & enb_d) ? (boot_q | phase_q[5:3]) : 3'h0;
    hh_n_d = ~(phase_q[2:0] & boot_q);
    hl_d = phase_q[5:3];
  end
  // serial master: idle clock low, change on rise, capture on fall
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rx_d = rx_q;
    last_d = last_q;
    bit_d = bit_q;
    cs_n_d = cs_n_q;
    sclk_d = sclk_q;
    si_d = si_q;
    q_pop = 1'h0;
    if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
    case (st_q)
      ST_IDLE: begin
        if (q_valid) begin
          q_pop = 1'h1;
          sh_d = q_data;
          cs_n_d = 1'h0;
          cnt_d = pdl_pkg::HALF_CNT;
          st_d = ST_LEAD;
        end
      end
      ST_LEAD, ST_LOW: begin
        if (cnt_q == 8'h00) begin
          sclk_d = 1'h1;
          si_d = sh_q[7];
          sh_d = {sh_q[6:0], 1'h0};
          cnt_d = pdl_pkg::HALF_CNT;
          st_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (cnt_q == 8'h00) begin
          sclk_d = 1'h0;
          rx_d = {rx_q[6:0], s2_q[2]};
          cnt_d = pdl_pkg::HALF_CNT;
          bit_d = bit_q + 3'h1;
          st_d = (bit_q == pdl_pkg::LAST_BIT) ? ST_LAG : ST_LOW;
        end
      end
      ST_LAG: begin
        if (cnt_q == 8'h00) begin
          cs_n_d = 1'h1;
          last_d = rx_q;
          cnt_d = pdl_pkg::HALF_CNT;
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_q == 8'h00) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        cs_n_d = 1'h1;
        sclk_d = 1'h0;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      last_q <= 8'h00;
      bit_q <= 3'h0;
      cs_n_q <= 1'h1;
      sclk_q <= 1'h0;
      si_q <= 1'h0;
      ack_q <= 1'h0;
      dat_q <= 32'h00000000;
      phase_q <= pdl_pkg::PHASE_RST;
      boot_q <= 3'h0;
      hh_n_q <= 3'h7;
      hl_q <= 3'h0;
      oe_n_q <= 1'h1;
      ena_q <= 1'h0;
      enb_q <= 1'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      last_q <= last_d;
      bit_q <= bit_d;
      cs_n_q <= cs_n_d;
      sclk_q <= sclk_d;
      si_q <= si_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      phase_q <= phase_d;
      boot_q <= boot_d;
      hh_n_q <= hh_n_d;
      hl_q <= hl_d;
      oe_n_q <= oe_n_d;
      ena_q <= ena_d;
      enb_q <= enb_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.si = si_q;
  assign link.host_high_n = hh_n_q;
  assign link.host_low = hl_q;
  assign link.cmd_oe_n = oe_n_q;
  assign link.drive_enable_a = ena_q;
  assign link.drive_enable_b = enb_q;
endmodule
`default_nettype wire

//--- test/pdl_chk.sv
// link checker: serial framing, clock rate, interrupt and pin defaults
`timescale 1ns/100ps
`default_nettype none
module pdl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic fault_irq,
  input wire logic cmd_oe_n,
  input wire logic phase_a_high_cmd_n,
  input wire logic phase_a_low_cmd
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic sclk_q;
  logic [7:0] half_q, half_d, rise_q, rise_d;
  // cycles since the last clock change and since the last rise, saturating
  always_comb begin
    half_d = (half_q == 8'hFF) ? half_q : half_q + 8'h01;
    rise_d = (rise_q == 8'hFF) ? rise_q : rise_q + 8'h01;
    if (sclk != sclk_q) begin
      half_d = 8'h00;
    end
    if (sclk && !sclk_q) begin
      rise_d = 8'h00;
    end
  end
  // saturated at reset so a first edge never looks too close
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 1'h0;
      half_q <= 8'hFF;
      rise_q <= 8'hFF;
    end else begin
      sclk_q <= sclk;
      half_q <= half_d;
      rise_q <= rise_d;
    end
  end
  a_so_hiz_idle: assert property (cs_n [*5] |-> so_oe_n)
    else $error("serial output driven while deselected");
  a_so_drive_sel: assert property ($fell(so_oe_n) |-> !cs_n)
    else $error("serial output enabled outside a frame");
  a_so_after_rise: assert property (
    $changed(so) && !so_oe_n && !$past(so_oe_n) && !cs_n |-> rise_q <= 8'h06)
    else $error("serial output moved away from a clock rise");
  a_si_stable_fall: assert property ($fell(sclk) |-> $stable(si))
    else $error("serial input moved at the sampling edge");
  a_sclk_in_frame: assert property ($rose(sclk) |-> !cs_n)
    else $error("serial clock pulsed while deselected");
  a_sclk_half_min: assert property ($changed(sclk) |-> half_q >= 8'h18)
    else $error("serial clock half period too short");
  a_irq_low_reset: assert property ($fell(rst_i) |-> !fault_irq)
    else $error("interrupt high right after reset");
  a_irq_clear_frame: assert property ($fell(fault_irq) |-> !cs_n)
    else $error("interrupt dropped without a serial command");
  a_pin_idle_off: assert property (
    cmd_oe_n |-> phase_a_high_cmd_n && !phase_a_low_cmd)
    else $error("undriven command pins not at off level");
  c_irq_cleared: cover property ($fell(fault_irq));
  c_frame_out: cover property ($fell(so_oe_n));
  c_clock_pulse: cover property ($rose(sclk) && !cs_n);
endmodule
`default_nettype wire

//--- test/tb_predriver_logic_interface.sv
// bench: both ends joined over the link, host driven over wishbone
`timescale 1ns/100ps
`default_nettype none
module tb_predriver_logic_interface;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic wb_ack;
  logic [7:0] fault = 8'h00;
  logic [7:0] sense = 8'h00;
  logic [7:0] thr = 8'h80;
  logic [2:0] high_gate;
  logic [2:0] low_gate;
  int error_cnt = 0;
  int num_checks = 0;
  pdl_if link_if ();
  // 250 MHz system clock
  always #2 clk_i = ~clk_i;
  pdl_host pdl_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_if),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  pdl_device pdl_device_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_if), .fault_i(fault), .sense_code_i(sense),
    .overcurrent_threshold_in_i(thr), .high_gate_o(high_gate),
    .low_gate_o(low_gate));
  pdl_chk pdl_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n(link_if.cs_n), .sclk(link_if.sclk), .si(link_if.si),
    .so(link_if.so), .so_oe_n(link_if.so_oe_n),
    .fault_irq(link_if.fault_irq), .cmd_oe_n(link_if.cmd_oe_n),
    .phase_a_high_cmd_n(link_if.phase_a_high_cmd_n),
    .phase_a_low_cmd(link_if.phase_a_low_cmd));
  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; held until ack is sampled or 4000 cycles pass
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    @(posedge clk_i);
    while (wb_ack !== 1'h1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    // a slave that never answers counts against the run
    if (n >= 4000) begin
      error_cnt++;
    end
    rd = wb_rdat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_i);
  endtask
  // settle first: busy may lag the write by a few cycles
  task automatic idle();
    int n;
    n = 0;
    repeat (8) @(posedge clk_i);
    wb(1'h0, pdl_pkg::ADDR_STATUS, 32'h0);
    while (rd[2] !== 1'h0 && n < 10000) begin
      wb(1'h0, pdl_pkg::ADDR_STATUS, 32'h0);
      n++;
    end
    // a link that stays busy counts against the run
    if (n >= 10000) begin
      error_cnt++;
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    wb(1'h1, pdl_pkg::ADDR_CMD, {24'h0, b});
    idle();
  endtask
  task automatic ph(input logic [8:0] v, input int wait_cyc);
    wb(1'h1, pdl_pkg::ADDR_PHASE, {23'h0, v});
    repeat (wait_cyc) @(posedge clk_i);
  endtask
  task automatic t_reset();
    wb(1'h0, pdl_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    chk("so_oe_n", 32'h1, 32'(link_if.so_oe_n));
    wb(1'h1, 4'hC, 32'hFFFFFFFF);
    wb(1'h0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'h0, pdl_pkg::ADDR_PHASE, 32'h0);
    chk("phase", 32'(pdl_pkg::PHASE_RST), rd);
  endtask
  // equal code is not over the threshold
  task automatic t_oc();
    sense <= 8'h40;
    thr <= 8'h40;
    repeat (4) @(posedge clk_i);
    chk("oc equal", 32'h0, 32'(link_if.overcurrent_flag_out));
    sense <= 8'h41;
    repeat (4) @(posedge clk_i);
    chk("oc above", 32'h1, 32'(link_if.overcurrent_flag_out));
    wb(1'h0, pdl_pkg::ADDR_STATUS, 32'h0);
    chk("status oc", 32'h1, 32'(rd[0]));
    sense <= 8'h3F;
    repeat (4) @(posedge clk_i);
    chk("oc below", 32'h0, 32'(link_if.overcurrent_flag_out));
  endtask
  task automatic t_irq();
    fault <= 8'h01;
    repeat (4) @(posedge clk_i);
    fault <= 8'h00;
    repeat (4) @(posedge clk_i);
    chk("irq set", 32'h1, 32'(link_if.fault_irq));
    cmd(8'h05);
    wb(1'h0, pdl_pkg::ADDR_CMD, 32'h0);
    chk("status byte", 32'h01, rd);
    chk("irq held", 32'h1, 32'(link_if.fault_irq));
    cmd(8'h1F);
    chk("irq clear", 32'h0, 32'(link_if.fault_irq));
    cmd(8'h21);
    fault <= 8'h01;
    repeat (4) @(posedge clk_i);
    chk("masked first", 32'h0, 32'(link_if.fault_irq));
    fault <= 8'h10;
    repeat (4) @(posedge clk_i);
    chk("live second", 32'h1, 32'(link_if.fault_irq));
    fault <= 8'h00;
    cmd(8'h10);
    cmd(8'h38);
    fault <= 8'h80;
    repeat (4) @(posedge clk_i);
    chk("masked second", 32'h0, 32'(link_if.fault_irq));
    fault <= 8'h02;
    repeat (4) @(posedge clk_i);
    chk("live first", 32'h1, 32'(link_if.fault_irq));
    fault <= 8'h00;
    cmd(8'h20);
    cmd(8'h30);
    cmd(8'h10);
    chk("irq clear", 32'h0, 32'(link_if.fault_irq));
  endtask
  // one byte goes straight into a frame, the rest fill the queue
  task automatic t_fifo();
    for (int i = 0; i <= pdl_pkg::FIFO_DEPTH; i++) begin
      wb(1'h1, pdl_pkg::ADDR_CMD, 32'h0);
    end
    wb(1'h0, pdl_pkg::ADDR_STATUS, 32'h0);
    chk("queue full", 32'(pdl_pkg::FIFO_DEPTH), 32'(rd[8:3]));
    wb(1'h1, pdl_pkg::ADDR_CMD, 32'h0);
    idle();
    chk("queue empty", 32'h0, 32'(rd[8:3]));
  endtask
  // deadtime is 125 cycles, checked well inside and past it
  task automatic t_drive();
    ph(9'h0C8, 140);
    chk("undriven low", 32'h0, 32'(low_gate));
    chk("undriven high", 32'h0, 32'(high_gate));
    ph(9'h1C1, 140);
    chk("high no pulse", 32'h0, 32'(high_gate));
    ph(9'h1C8, 140);
    chk("low on", 32'h1, 32'(low_gate));
    ph(9'h1C1, 10);
    chk("low dropped", 32'h0, 32'(low_gate));
    // new leading edge inside deadtime; enables stay up, bootstrap kept
    ph(9'h1C0, 0);
    ph(9'h1C1, 0);
    chk("high waits", 32'h0, 32'(high_gate));
    repeat (140) @(posedge clk_i);
    chk("high on", 32'h1, 32'(high_gate));
    ph(9'h1C0, 140);
    chk("high off", 32'h0, 32'(high_gate));
    ph(9'h1C8, 10);
    chk("low at once", 32'h1, 32'(low_gate));
    ph(9'h188, 10);
    chk("enable low", 32'h0, 32'(low_gate));
    ph(9'h1C1, 140);
    chk("high re-enable", 32'h0, 32'(high_gate));
    ph(9'h000, 4);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_oc();
    t_irq();
    t_fifo();
    t_drive();
    print_verdict();
  end
  // watchdog: the run needs about half this span
  initial begin
    #300000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
